// *** include/eec_params.svh ***
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef EEC_PARAMS_SVH
`define EEC_PARAMS_SVH

// ==========================================================
// Register map (byte addresses, one aligned word each)
`define EEC_OFF_ADDR 8'h00
`define EEC_OFF_DATA 8'h04
`define EEC_OFF_CTRL 8'h08

// ==========================================================
// Control register fields
`define EEC_BIT_RD 0
`define EEC_BIT_PE 1
`define EEC_BIT_MPE 2
`define EEC_BIT_RIE 3
`define EEC_MODE_LO 4
`define EEC_MODE_HI 5

// ==========================================================
// Programming modes
`define EEC_MODE_ATOMIC 2'h0
`define EEC_MODE_ERASE 2'h1
`define EEC_MODE_WRITE 2'h2
`define EEC_MODE_RSVD 2'h3

// ==========================================================
// Geometry, reset values, timing
`define EEC_ADDR_W 12
`define EEC_ERASED_BYTE 8'hff
`define EEC_RD_STALL 3'h4
`define EEC_PG_STALL 3'h2
`define EEC_MPE_HOLD 3'h4
`define EEC_WRITE_TIME_US 4500
`define EEC_ERASE_TIME_US 8500
`define EEC_US_PER_MS 1000
`define EEC_OSC_KHZ 1000
`define EEC_TIMER_W 16

`endif

// *** include/eec_pkg.sv ***
// Purpose: Shared types of the nonvolatile access controller
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Constants live in eec_params.svh
`default_nettype none

package eec_pkg;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } eec_ahb_req_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } eec_ahb_rsp_s;

  // ==========================================================
  // Latched programming operation
  typedef logic [1:0] eec_mode_t;

  typedef struct packed {
    eec_mode_t mode;
    logic [11:0] addr;
    logic [7:0] data;
  } eec_op_s;

  typedef enum logic {
    EEC_IDLE,
    EEC_PROG
  } eec_state_e;

endpackage

`default_nettype wire

// *** hdl/eec_array.sv ***
// Purpose: Byte-wide nonvolatile storage array
// Assumes: One operation commit per cycle at most
// Notes: Contents are not reset, as befits nonvolatile storage
`include "eec_params.svh"
`default_nettype none

module eec_array #(
  parameter int ADDR_W = `EEC_ADDR_W
) (
  input wire logic clock, // Core clock
  input wire logic [ADDR_W-1:0] rd_addr, // Read address
  output logic [7:0] rd_data, // Registered read byte
  input wire logic op_go, // Commit pulse
  input wire eec_pkg::eec_op_s op // Operation to commit
);

  logic [7:0] mem_q [2**ADDR_W];
  logic [7:0] rd_d;
  logic [7:0] wr_byte;
  logic [ADDR_W-1:0] wr_addr;

  if (ADDR_W != $bits(op.addr)) begin : g_bad_width
    $error("eec_array: ADDR_W must match the operation address width");
  end

  // ==========================================================
  // Next values
  always_comb begin
    wr_addr = op.addr;
    rd_d = mem_q[rd_addr];
    case (op.mode)
      `EEC_MODE_ATOMIC: wr_byte = op.data;
      `EEC_MODE_ERASE: wr_byte = `EEC_ERASED_BYTE;
      // Write-only can clear bits but never set them
      default: wr_byte = mem_q[wr_addr] & op.data;
    endcase
  end

  // ==========================================================
  // Storage
  always_ff @(posedge clock) begin
    rd_data <= rd_d;
    if (op_go) begin
      mem_q[wr_addr] <= wr_byte;
    end
  end

endmodule

`default_nettype wire

// *** hdl/eec_ctrl.sv ***
// Purpose: Processor-side controller for the byte-wide data EEPROM
// Assumes: AHB-Lite single word transfers, 40 MHz core clock
// Notes: Programming time counts ticks of the calibrated oscillator
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`include "eec_params.svh"
`default_nettype none

// Functional notes
// - The array is a flat 4K-byte space, read one byte at a time.
// - A read request holds the bus for four cycles, then the byte sits in the data register.
// - An accepted programming request holds the bus for two cycles while programming runs on.
// - A write operation keeps busy set for the write time of 4.5 ms.
// - An erase operation keeps busy set for the erase time of 8.5 ms.
// - Programming time is counted on the calibrated oscillator, not the core clock.
// - Busy is readable so software can poll for the next byte.
// - Programming starts only after the guarded enable-then-strobe sequence; other strobes are rejected.
// - Mode field: 0 erase and write, 1 erase only, 2 write only, 3 reserved.
// - Master enable clears itself four cycles after set; the strobe only acts while it is set.
// - Mode field writes are ignored while the strobe or busy bit is set.
// - With ready interrupt and global interrupts enabled, the request holds while the strobe is clear.
module eec_ctrl #(
  parameter int OSC_KHZ = `EEC_OSC_KHZ,
  parameter int WRITE_TICKS = `EEC_WRITE_TIME_US * OSC_KHZ / `EEC_US_PER_MS,
  parameter int ERASE_TICKS = `EEC_ERASE_TIME_US * OSC_KHZ / `EEC_US_PER_MS,
  parameter int TIMER_W = `EEC_TIMER_W
) (
  input wire logic clock, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire eec_pkg::eec_ahb_req_s ahb_req, // AHB-Lite request
  output var eec_pkg::eec_ahb_rsp_s ahb_rsp, // AHB-Lite response
  input wire logic osc_clk, // Calibrated oscillator, async
  input wire logic global_irq_en, // Core global interrupt enable
  output logic ready_irq // Ready interrupt request level
);

  if (WRITE_TICKS < 1 || ERASE_TICKS < 1 || WRITE_TICKS + ERASE_TICKS >= 2**TIMER_W) begin : g_bad_ticks
    $error("eec_ctrl: programming tick counts do not fit the timer");
  end

  // ==========================================================
  // Helpers
  function automatic logic [TIMER_W-1:0] ticks_for(input eec_pkg::eec_mode_t mode);
    case (mode)
      `EEC_MODE_ATOMIC: ticks_for = TIMER_W'(WRITE_TICKS + ERASE_TICKS);
      `EEC_MODE_ERASE: ticks_for = TIMER_W'(ERASE_TICKS);
      default: ticks_for = TIMER_W'(WRITE_TICKS);
    endcase
  endfunction

  // ==========================================================
  // State
  logic [`EEC_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  eec_pkg::eec_mode_t mode_q, mode_d;
  logic rie_q, rie_d;
  logic mpe_q, mpe_d;
  logic [2:0] mpe_cnt_q, mpe_cnt_d;
  eec_pkg::eec_state_e state_q, state_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  eec_pkg::eec_op_s op_q, op_d;
  logic [2:0] stall_q, stall_d;
  logic rd_pend_q, rd_pend_d;
  logic [2:0] osc_s_q;
  logic osc_lvl_q, osc_lvl_d;
  logic dp_q, dp_d;
  logic dp_wr_q, dp_wr_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic done_q, done_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [7:0] arr_rd;
  logic op_go;
  logic osc_tick;
  logic wr_now;
  logic ctrl_wr;
  logic rd_start;
  logic pg_start;
  logic mpe_set;
  logic ready_c;
  logic busy;
  logic [31:0] wd;

  assign busy = (state_q == eec_pkg::EEC_PROG);
  assign wd = ahb_req.hwdata;

  // ==========================================================
  // Storage array
  eec_array #(
    .ADDR_W(`EEC_ADDR_W)
  ) u_array (
    .clock(clock),
    .rd_addr(addr_q),
    .rd_data(arr_rd),
    .op_go(op_go),
    .op(op_q)
  );

  // ==========================================================
  // Oscillator synchroniser: three stages, stage 0 feeds stage 1 only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_s_q <= 3'h0;
    end else begin
      osc_s_q <= {osc_s_q[1:0], osc_clk};
    end
  end

  // ==========================================================
  // Next values
  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    mode_d = mode_q;
    rie_d = rie_q;
    mpe_d = mpe_q;
    mpe_cnt_d = mpe_cnt_q;
    state_d = state_q;
    timer_d = timer_q;
    op_d = op_q;
    stall_d = stall_q;
    rd_pend_d = rd_pend_q;
    osc_lvl_d = osc_lvl_q;
    dp_d = dp_q;
    dp_wr_d = dp_wr_q;
    dp_addr_d = dp_addr_q;
    done_d = done_q;
    hrdata_d = hrdata_q;
    op_go = 1'b0;
    rd_start = 1'b0;
    pg_start = 1'b0;
    mpe_set = 1'b0;

    // Rising level change counts once stages one and two agree
    osc_tick = 1'b0;
    if (osc_s_q[1] == osc_s_q[2]) begin
      osc_lvl_d = osc_s_q[1];
      osc_tick = osc_s_q[1] & ~osc_lvl_q;
    end

    // Master enable self-clear
    if (mpe_q) begin
      if (mpe_cnt_q == 3'h0) begin
        mpe_d = 1'b0;
      end else begin
        mpe_cnt_d = mpe_cnt_q - 3'h1;
      end
    end

    // Self-timed programming engine
    case (state_q)
      eec_pkg::EEC_PROG: begin
        if (osc_tick) begin
          if (timer_q == TIMER_W'(1)) begin
            op_go = 1'b1;
            state_d = eec_pkg::EEC_IDLE;
          end else begin
            timer_d = timer_q - TIMER_W'(1);
          end
        end
      end
      default: begin
      end
    endcase

    // Bus stall countdown and read capture
    if (stall_q != 3'h0) begin
      stall_d = stall_q - 3'h1;
      if (stall_q == 3'h1 && rd_pend_q) begin
        data_d = arr_rd;
        rd_pend_d = 1'b0;
      end
    end

    // Register write in the first data phase cycle
    wr_now = dp_q & dp_wr_q & ~done_q;
    ctrl_wr = wr_now && (dp_addr_q == `EEC_OFF_CTRL);
    if (wr_now) begin
      done_d = 1'b1;
      if (dp_addr_q == `EEC_OFF_ADDR) begin
        addr_d = wd[`EEC_ADDR_W-1:0];
      end else if (dp_addr_q == `EEC_OFF_DATA) begin
        data_d = wd[7:0];
      end else if (dp_addr_q == `EEC_OFF_CTRL) begin
        rie_d = wd[`EEC_BIT_RIE];
        if (!busy) begin
          mode_d = wd[`EEC_MODE_HI:`EEC_MODE_LO];
        end
        if (wd[`EEC_BIT_MPE]) begin
          mpe_set = 1'b1;
          mpe_d = 1'b1;
          mpe_cnt_d = `EEC_MPE_HOLD - 3'h1;
        end
        // Strobe needs the enable armed by an earlier write
        if (wd[`EEC_BIT_PE] && mpe_q && !busy && mode_d != `EEC_MODE_RSVD) begin
          pg_start = 1'b1;
          state_d = eec_pkg::EEC_PROG;
          op_d = '{mode: mode_d, addr: addr_q, data: data_q};
          timer_d = ticks_for(mode_d);
          stall_d = `EEC_PG_STALL - 3'h1;
        end else if (wd[`EEC_BIT_RD] && !busy) begin
          rd_start = 1'b1;
          rd_pend_d = 1'b1;
          stall_d = `EEC_RD_STALL - 3'h1;
        end
      end
    end

    // Wait states cover the first data cycle of a stalling write too
    ready_c = (stall_q == 3'h0) && !pg_start && !rd_start;

    if (dp_q && ready_c) begin
      dp_d = 1'b0;
    end
    if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
      dp_d = 1'b1;
      dp_wr_d = ahb_req.hwrite;
      dp_addr_d = ahb_req.haddr[7:0];
      done_d = 1'b0;
      hrdata_d = 32'h0;
      if (!ahb_req.hwrite) begin
        if (ahb_req.haddr[7:0] == `EEC_OFF_ADDR) begin
          hrdata_d[`EEC_ADDR_W-1:0] = addr_d;
        end else if (ahb_req.haddr[7:0] == `EEC_OFF_DATA) begin
          hrdata_d[7:0] = data_d;
        end else if (ahb_req.haddr[7:0] == `EEC_OFF_CTRL) begin
          hrdata_d[`EEC_MODE_HI:`EEC_MODE_LO] = mode_d;
          hrdata_d[`EEC_BIT_RIE] = rie_d;
          hrdata_d[`EEC_BIT_MPE] = mpe_d;
          hrdata_d[`EEC_BIT_PE] = (state_d == eec_pkg::EEC_PROG);
        end
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= '0;
      data_q <= 8'h0;
      mode_q <= `EEC_MODE_ATOMIC;
      rie_q <= 1'b0;
      mpe_q <= 1'b0;
      mpe_cnt_q <= 3'h0;
      state_q <= eec_pkg::EEC_IDLE;
      timer_q <= '0;
      op_q <= '0;
      stall_q <= 3'h0;
      rd_pend_q <= 1'b0;
      osc_lvl_q <= 1'b0;
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h0;
      done_q <= 1'b0;
      hrdata_q <= 32'h0;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
      mode_q <= mode_d;
      rie_q <= rie_d;
      mpe_q <= mpe_d;
      mpe_cnt_q <= mpe_cnt_d;
      state_q <= state_d;
      timer_q <= timer_d;
      op_q <= op_d;
      stall_q <= stall_d;
      rd_pend_q <= rd_pend_d;
      osc_lvl_q <= osc_lvl_d;
      dp_q <= dp_d;
      dp_wr_q <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      done_q <= done_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    ahb_rsp.hreadyout = ready_c;
    ahb_rsp.hresp = 1'b0;
    ahb_rsp.hrdata = hrdata_q;
    ready_irq = rie_q & global_irq_en & ~busy;
  end

  // ==========================================================
  // Checks
  logic [TIMER_W-1:0] tick_cnt_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= '0;
    end else if (pg_start) begin
      tick_cnt_q <= '0;
    end else if (busy && osc_tick) begin
      tick_cnt_q <= tick_cnt_q + TIMER_W'(1);
    end
  end

  a_read_stall_len: assert property (@(posedge clock) disable iff (!arst_n)
    rd_start |-> !ahb_rsp.hreadyout ##1 !ahb_rsp.hreadyout[*3] ##1 ahb_rsp.hreadyout)
    else $error("read stall is not four cycles");

  a_read_data_loaded: assert property (@(posedge clock) disable iff (!arst_n)
    rd_start |-> ##4 (data_q == $past(arr_rd)))
    else $error("read byte not in data register after stall");

  a_prog_stall_len: assert property (@(posedge clock) disable iff (!arst_n)
    pg_start |-> !ahb_rsp.hreadyout ##1 !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout)
    else $error("programming stall is not two cycles");

  a_mpe_held: assert property (@(posedge clock) disable iff (!arst_n)
    mpe_set |=> mpe_q[*4])
    else $error("master enable dropped early");

  a_mpe_self_clear: assert property (@(posedge clock) disable iff (!arst_n)
    mpe_set ##1 !mpe_set[*4] |=> !mpe_q)
    else $error("master enable not cleared after four cycles");

  a_strobe_gated: assert property (@(posedge clock) disable iff (!arst_n)
    (ctrl_wr && wd[`EEC_BIT_PE] && !mpe_q && !busy) |=> !busy)
    else $error("strobe accepted without master enable");

  a_mode_frozen: assert property (@(posedge clock) disable iff (!arst_n)
    busy |=> (mode_q == $past(mode_q)))
    else $error("mode field changed while busy");

  a_busy_duration: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(busy) |-> (tick_cnt_q == ticks_for(op_q.mode)))
    else $error("busy did not last the programmed tick count");

  a_busy_on_accept: assert property (@(posedge clock) disable iff (!arst_n)
    pg_start |=> busy && !ready_irq)
    else $error("strobe not set after acceptance");

  a_irq_on_ready: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(busy) && rie_q && global_irq_en) |-> ready_irq)
    else $error("ready interrupt missing after completion");

endmodule

`default_nettype wire

// *** verification/eec_core_model.sv ***
// Purpose: Processor core model issuing AHB-Lite register accesses
// Assumes: Each task is entered just after a rising clock edge
// Notes: Answers are sampled at the falling edge before the taking edge
`include "eec_params.svh"
`default_nettype none

module eec_core_model (
  input wire logic clock, // Core clock
  output var eec_pkg::eec_ahb_req_s ahb_req, // Request to controller
  input wire eec_pkg::eec_ahb_rsp_s ahb_rsp // Response from controller
);
  timeunit 1ns;
  timeprecision 1ps;
  eec_pkg::eec_ahb_req_s req_q;

  initial begin
    req_q = '0;
  end

  // Single slave, so its ready is the bus ready
  always_comb begin
    ahb_req = req_q;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  // ==========================================================
  // One single word transfer
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output int waits);
    logic rdy;
    waits = 0;
    req_q.hsel <= 1'b1;
    req_q.htrans <= 2'h2;
    req_q.haddr <= {24'h0, addr};
    req_q.hwrite <= wr;
    req_q.hsize <= 3'h2;
    do begin
      @(negedge clock);
      rdy = ahb_rsp.hreadyout;
      @(posedge clock);
    end while (rdy !== 1'b1);
    req_q.hsel <= 1'b0;
    req_q.htrans <= 2'h0;
    req_q.hwdata <= wd;
    do begin
      @(negedge clock);
      rdy = ahb_rsp.hreadyout;
      rd = ahb_rsp.hrdata;
      if (rdy !== 1'b1) begin
        waits++;
      end
      @(posedge clock);
    // No cycle limit here: only the bench watchdog ends a stuck wait
    end while (rdy !== 1'b1);
  endtask

  // ==========================================================
  // Guarded programming sequence; no flash loader runs here
  task automatic prog_byte(input logic [1:0] mode, input logic [11:0] a, input logic [7:0] d,
                           input logic [31:0] extra, output int waits);
    logic [31:0] r;
    int w;
    r = 32'h2;
    for (int n = 0; n < 400 && r[1] === 1'b1; n++) begin
      xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
    end
    xfer(1'b1, `EEC_OFF_ADDR, {20'h0, a}, r, w);
    xfer(1'b1, `EEC_OFF_DATA, {24'h0, d}, r, w);
    xfer(1'b1, `EEC_OFF_CTRL, extra | {26'h0, mode, 4'h4}, r, w);
    xfer(1'b1, `EEC_OFF_CTRL, extra | {26'h0, mode, 4'h6}, r, waits);
  endtask
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the nonvolatile access controller
// Assumes: Short tick counts; oscillator of 8 core clocks per tick
// Notes: Byte contents are modelled in an associative array
`include "eec_params.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WT = 3;
  localparam int ET = 5;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic osc_clk = 1'b0;
  logic global_irq_en = 1'b1;
  logic ready_irq;
  eec_pkg::eec_ahb_req_s ahb_req;
  eec_pkg::eec_ahb_rsp_s ahb_rsp;
  int err_total = 0;
  int tests_run = 0;
  int seed = 77;
  int cyc = 0;
  int mem[int];

  always #12.5 clock = ~clock;
  // Unrelated phase to the core clock
  always #100.3 osc_clk = ~osc_clk;
  always @(posedge clock) cyc <= cyc + 1;

  eec_ctrl #(.WRITE_TICKS(WT), .ERASE_TICKS(ET)) i_dut (
    .clock(clock), .arst_n(arst_n), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .osc_clk(osc_clk), .global_irq_en(global_irq_en), .ready_irq(ready_irq));
  eec_core_model i_core (.clock(clock), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));

  // ==========================================================
  // Checking and verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Irq is combinational; look away from the edge
  task automatic irq_chk(input logic exp);
    @(negedge clock);
    chk("ready_irq", {31'h0, exp}, {31'h0, ready_irq});
    @(posedge clock);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [11:0] a;
    logic [7:0] d;
    logic [1:0] modes[4];
    int w;
    int t0;
    int ticks;
    modes = '{2'h1, 2'h2, 2'h2, 2'h0};
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
    chk("ctrl_reset", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, ahb_rsp.hresp});
    i_core.xfer(1'b0, 8'h0c, 32'h0, r, w);
    chk("unmapped", 32'h0, r);
    irq_chk(1'b0);
    i_core.xfer(1'b1, `EEC_OFF_CTRL, 32'h2, r, w);
    chk("lone_strobe_wait", 32'h0, w);
    i_core.xfer(1'b1, `EEC_OFF_CTRL, 32'h4, r, w);
    repeat (6) @(posedge clock);
    i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
    chk("enable_expired", 32'h0, r);
    i_core.xfer(1'b1, `EEC_OFF_CTRL, 32'h6, r, w);
    chk("same_write_strobe", 32'h0, w);
    i_core.prog_byte(2'h3, 12'h0, 8'h0, 32'h0, w);
    chk("reserved_wait", 32'h0, w);
    i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
    chk("reserved_busy", 32'h0, r[1]);
    a = 12'($random(seed));
    foreach (modes[i]) begin
      d = 8'($random(seed));
      i_core.prog_byte(modes[i], a, d, 32'h8, w);
      t0 = cyc;
      chk("strobe_wait", 32'h2, w);
      i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
      chk("busy_set", 32'h1, r[1]);
      irq_chk(1'b0);
      i_core.xfer(1'b1, `EEC_OFF_CTRL, {26'h0, ~modes[i], 4'h8}, r, w);
      i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
      chk("mode_held", modes[i], r[5:4]);
      for (int n = 0; n < 400 && r[1] === 1'b1; n++) begin
        i_core.xfer(1'b0, `EEC_OFF_CTRL, 32'h0, r, w);
      end
      ticks = (modes[i] == 2'h1) ? ET : (modes[i] == 2'h2) ? WT : ET + WT;
      chk("prog_time", 32'h1, (cyc - t0 >= ticks * 8 - 8) && (cyc - t0 <= ticks * 8 + 20));
      irq_chk(1'b1);
      mem[a] = (modes[i] == 2'h1) ? 255 : (modes[i] == 2'h2) ? (mem[a] & d) : d;
      i_core.xfer(1'b1, `EEC_OFF_CTRL, 32'h9, r, w);
      chk("read_wait", 32'h4, w);
      i_core.xfer(1'b0, `EEC_OFF_DATA, 32'h0, r, w);
      chk("read_byte", mem[a], r);
    end
    global_irq_en <= 1'b0;
    @(posedge clock);
    irq_chk(1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
